/* dv/pmrb_adc_model.sv */
/*
 * analog front end model: turns the levels chosen by the bench into
 * converter samples on the sample carrier.
 * assumes levels change only while no conversion result is expected.
 */
module pmrb_adc_model (
    input wire logic signed [15:0] shunt_lvl, // shunt level code, twos complement
    input wire logic [15:0] bus_lvl,          // bus level code
    output pmrb_pkg::pmrb_sample_t sample     // samples towards the bank
);
    timeunit 1ns;
    timeprecision 1ns;
    import pmrb_pkg::*;
    // shunt passes as is, negative drops included; the bus input only sees
    // positive voltage, so its top bit never sets
    assign sample = '{shunt: shunt_lvl, bus: {1'b0, bus_lvl[14:0]}};
endmodule // pmrb_adc_model

/* dv/pmrb_bank_checker.sv */
/*
 * port checker for the register bank, bound into every bank instance.
 * assumes the single sys_clk domain and the synchronous rst.
 */
module pmrb_bank_checker (
    input wire logic sys_clk,                  // system clock
    input wire logic rst,                      // synchronous reset
    input wire pmrb_pkg::pmrb_req_t req,       // byte requests
    input wire logic xfer_end,                 // stop pulse
    input wire pmrb_pkg::pmrb_sample_t sample, // converter samples
    input wire logic [7:0] rd_data,            // read byte
    input wire logic [15:0] config_out,        // live configuration
    input wire logic conv_busy,                // sequencer busy
    input wire logic conv_ready                // ready flag
);
    timeunit 1ns;
    timeprecision 1ns;
    import pmrb_pkg::*;
    logic [7:0] ptr_r, ptr_nxt;         // shadow of the pointer
    logic ptr_due_r, ptr_due_nxt;       // next write byte is a pointer
    // shadow the pointer so that reads can be tied to their target
    always_comb begin
        ptr_nxt = ptr_r;
        ptr_due_nxt = ptr_due_r | req.start;
        if (req.wr && ptr_due_r) begin
            ptr_nxt = req.data;
            ptr_due_nxt = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptr_r <= 8'h00;
            ptr_due_r <= 1'b0;
        end else begin
            ptr_r <= ptr_nxt;
            ptr_due_r <= ptr_due_nxt;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a read strobe aimed at a given pointer
    sequence rd_at_s(logic [7:0] p);
        req.rd && ptr_r == p;
    endsequence
    // sequencer parked for two cycles
    sequence parked_s;
        !conv_busy [*2];
    endsequence
    // reset must be checked while it is asserted, so it is not disabled here
    reset_defaults_a: assert property (disable iff (1'b0) rst |=>
        config_out == CFG_RESET && !conv_busy && !conv_ready && rd_data == 8'h00)
        else $error("defaults missing after reset");
    fixed_bits_a: assert property (config_out[14:12] == 3'b100)
        else $error("fixed config bits altered");
    self_clear_a: assert property (!config_out[CFG_RST_BIT])
        else $error("reset bit stuck");
    cfg_stable_a: assert property (!req.wr && !$past(req.wr) && config_out[2]
        |=> $stable(config_out)) else $error("config changed without write");
    write_halt_a: assert property ($changed(config_out) && !$past(rst) |-> parked_s)
        else $error("conversion ran across config write");
    idle_mode_a: assert property ((config_out[1:0] == 2'b00) [*2] |-> !conv_busy)
        else $error("converting in power-down");
    ready_cause_a: assert property ($rose(conv_ready) |-> $past(conv_busy))
        else $error("ready without conversion");
    die_identifier_a: assert property (rd_at_s(PTR_DIE_IDENTIFIER) |=>
        rd_data == DIE_IDENTIFIER_VALUE[15:8] || rd_data == DIE_IDENTIFIER_VALUE[7:0])
        else $error("die identifier byte wrong");
    undef_zero_a: assert property (rd_at_s(8'h08) |=> rd_data == 8'h00)
        else $error("undefined pointer not zero");
endmodule // pmrb_bank_checker

bind pmrb_bank pmrb_bank_checker u_chk (.sys_clk(sys_clk), .rst(rst), .req(req),
    .xfer_end(xfer_end), .sample(sample), .rd_data(rd_data), .config_out(config_out),
    .conv_busy(conv_busy), .conv_ready(conv_ready));

/* dv/pmrb_bank_tb.sv */
/*
 * testbench for the register bank: byte-level host tasks and directed tests.
 * assumes the analog model and the bound checker are compiled beside it.
 */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pmrb_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmrb_pkg::*;
    logic sys_clk, rst, xfer_end;      // clock, reset, stop pulse
    pmrb_req_t req;                     // host byte requests
    pmrb_sample_t sample;               // model samples
    logic [7:0] rd_data;                // read byte
    logic [15:0] config_out, rv;        // live config, read value
    logic conv_busy, conv_ready;        // sequencer status
    logic signed [15:0] shunt_lvl;      // shunt level to model
    logic [15:0] bus_lvl;               // bus level to model
    int mismatches = 0;
    int compares = 0;
    logic [7:0] ptrs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                              8'hFF, 8'h08};
    logic [15:0] dflt [10] = '{CFG_RESET, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                               16'h0000, 16'h0000, 16'h0000, DIE_IDENTIFIER_VALUE, 16'h0000};
    pmrb_bank uut (.sys_clk(sys_clk), .rst(rst), .req(req), .xfer_end(xfer_end),
        .sample(sample), .rd_data(rd_data), .config_out(config_out),
        .conv_busy(conv_busy), .conv_ready(conv_ready));
    pmrb_adc_model u_adc (.shunt_lvl(shunt_lvl), .bus_lvl(bus_lvl), .sample(sample));
    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // one request beat: changed just after an edge, held across the next
    task automatic beat(input logic s, w, r, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        req = '{start: s, wr: w, rd: r, data: d};
    endtask
    // start, pointer, high byte, low byte, then stop
    task automatic reg_write(input logic [7:0] p, input logic [15:0] v);
        beat(1'b1, 1'b0, 1'b0, 8'h00);
        beat(1'b0, 1'b1, 1'b0, p);
        beat(1'b0, 1'b1, 1'b0, v[15:8]);
        beat(1'b0, 1'b1, 1'b0, v[7:0]);
        @(posedge sys_clk);
        #1;
        req = '0;
        xfer_end = 1'b1;
        @(posedge sys_clk);
        #1;
        xfer_end = 1'b0;
    endtask
    // pointer write, repeated start, two back to back read strobes
    task automatic reg_read(input logic [7:0] p, output logic [15:0] v);
        beat(1'b1, 1'b0, 1'b0, 8'h00);
        beat(1'b0, 1'b1, 1'b0, p);
        beat(1'b1, 1'b0, 1'b0, 8'h00);
        beat(1'b0, 1'b0, 1'b1, 8'h00);
        beat(1'b0, 1'b0, 1'b1, 8'h00);
        // high byte stands from the edge that took the first strobe
        v[15:8] = rd_data;
        @(posedge sys_clk);
        #1;
        req = '0;
        v[7:0] = rd_data;
    endtask
    // read a register and compare it with its expected word
    task automatic expect_reg(input string nm, input logic [7:0] p, input logic [15:0] e);
        reg_read(p, rv);
        `CHK(nm, e, rv)
    endtask
    // bounded wait for a finished conversion
    task automatic wait_ready(input int lim);
        int n = 0;
        while (conv_ready !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("conv_ready", 1'b1, conv_ready)
    endtask
    // verdict and end of run
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog: the run needs about 70000 cycles
    initial begin
        #(50 * 95000);
        mismatches++;
        results();
    end
    // directed sequence
    initial begin
        rst = 1'b1;
        req = '0;
        xfer_end = 1'b0;
        shunt_lvl = 16'sh3E80;
        bus_lvl = 16'h2560;
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        `CHK("config_out", CFG_RESET, config_out)
        for (int i = 0; i < 10; i++) begin
            expect_reg("reset value", ptrs[i], dflt[i]);
        end
        // config reads must not stop the power-up conversion
        `CHK("busy after reads", 1'b1, conv_busy)
        reg_write(PTR_SHUNT, 16'hAAAA);
        reg_write(PTR_CURRENT, 16'h5555);
        expect_reg("shunt read-only", PTR_SHUNT, 16'h0000);
        expect_reg("current read-only", PTR_CURRENT, 16'h0000);
        wait_ready(50000);
        expect_reg("shunt default run", PTR_SHUNT, 16'h3E80);
        expect_reg("bus default run", PTR_BUS, 16'h2560);
        expect_reg("current uncal", PTR_CURRENT, 16'h0000);
        expect_reg("power uncal", PTR_POWER, 16'h0000);
        reg_write(PTR_CALIB, 16'h0A00);
        expect_reg("calibration", PTR_CALIB, 16'h0A00);
        expect_reg("current", PTR_CURRENT, 16'h4E20);
        expect_reg("power", PTR_POWER, 16'h2560);
        reg_write(PTR_LIMIT, 16'h1234);
        expect_reg("limit", PTR_LIMIT, 16'h1234);
        reg_write(PTR_MASK, 16'hFFFF);
        reg_read(PTR_MASK, rv);
        `CHK("mask", 16'hFFF0, rv & 16'hFFF0)
        // four averages, both conversion times at the shortest code
        shunt_lvl = 16'shF9C0;
        bus_lvl = 16'h1000;
        reg_write(PTR_CONFIG, 16'h7207);
        expect_reg("config fixed bits", PTR_CONFIG, 16'h4207);
        reg_read(PTR_MASK, rv);
        `CHK("busy after restart", 1'b1, conv_busy)
        wait_ready(30000);
        expect_reg("shunt averaged", PTR_SHUNT, 16'hF9C0);
        expect_reg("bus averaged", PTR_BUS, 16'h1000);
        expect_reg("negative current", PTR_CURRENT, 16'hF830);
        reg_write(PTR_CONFIG, 16'h4000);
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK("power-down busy", 1'b0, conv_busy)
        reg_write(PTR_CONFIG, 16'h4001);
        reg_read(PTR_MASK, rv);
        wait_ready(4000);
        expect_reg("triggered mode done", PTR_CONFIG, 16'h4000);
        reg_write(PTR_CONFIG, 16'h8000);
        expect_reg("soft reset config", PTR_CONFIG, CFG_RESET);
        expect_reg("soft reset cal", PTR_CALIB, 16'h0000);
        expect_reg("soft reset limit", PTR_LIMIT, 16'h0000);
        expect_reg("soft reset current", PTR_CURRENT, 16'h0000);
        results();
    end
endmodule // pmrb_bank_tb

/* rtl/pmrb_bank.sv */
/*
 * power monitor register bank: pointer addressed 16-bit registers,
 * conversion sequencer with averaging and the current/power arithmetic.
 * assumes a serial front end that delivers bytes as one-cycle strobes on
 * sys_clk and an analog front end whose samples are stable when read.
 */
module pmrb_bank (
    input wire logic sys_clk,                      // 20 MHz system clock
    input wire logic rst,                          // synchronous reset, active high
    input wire pmrb_pkg::pmrb_req_t req,           // byte requests from serial logic
    input wire logic xfer_end,                     // stop condition, one-cycle pulse
    input wire pmrb_pkg::pmrb_sample_t sample,     // raw converter samples
    output logic [7:0] rd_data,                    // read byte, valid after rd
    output logic [15:0] config_out,                // live configuration word
    output logic conv_busy,                        // conversion sequencer active
    output logic conv_ready                        // conversion ready flag
);
    import pmrb_pkg::*;

    // register state
    logic [7:0] ptr_r, ptr_nxt;              // selected register
    logic [1:0] phase_r, phase_nxt;          // 0 pointer, 1 high byte, 2 low byte
    logic [7:0] hold_r, hold_nxt;            // high write byte awaiting low byte
    logic [7:0] rlow_r, rlow_nxt;            // low read byte captured with high byte
    logic [7:0] rd_r, rd_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [15:0] shunt_r, shunt_nxt;
    logic [15:0] bus_r, bus_nxt;
    logic [15:0] power_r, power_nxt;
    logic [15:0] current_r, current_nxt;
    logic [15:0] cal_r, cal_nxt;
    logic [15:0] mask_r, mask_nxt;
    logic [15:0] limit_r, limit_nxt;
    logic cfg_wr_r, cfg_wr_nxt;              // config written, restart pending
    logic ready_r, ready_nxt;
    // sequencer state
    pmrb_state_t st_r, st_nxt;
    logic [CNT_W-1:0] tmr_r, tmr_nxt;        // conversion time counter
    logic [10:0] smp_r, smp_nxt;             // samples taken in this average
    logic signed [26:0] acc_sh_r, acc_sh_nxt;
    logic [26:0] acc_bus_r, acc_bus_nxt;
    logic busy_r, busy_nxt;

    // combinational helpers
    logic [15:0] sel_word;
    logic [15:0] wr_word;
    logic wr_full;
    logic [2:0] mode;
    logic [10:0] avg_n;
    logic [31:0] cur_prod;
    logic [31:0] pow_prod;
    logic cfg_write;                         // full word landing on the configuration
    logic soft_rst;                          // reset bit written as one
    logic publish;                           // averaged result lands this cycle

    // read mux; reading alters no register contents except the ready flag on a mask read
    // an if chain keeps every undefined pointer on the final else
    always_comb begin
        if (ptr_r == PTR_CONFIG) begin
            sel_word = cfg_r;
        end else if (ptr_r == PTR_SHUNT) begin
            sel_word = shunt_r;
        end else if (ptr_r == PTR_BUS) begin
            sel_word = bus_r;
        end else if (ptr_r == PTR_POWER) begin
            sel_word = power_r;
        end else if (ptr_r == PTR_CURRENT) begin
            sel_word = current_r;
        end else if (ptr_r == PTR_CALIB) begin
            sel_word = cal_r;
        end else if (ptr_r == PTR_MASK) begin
            sel_word = mask_r;
        end else if (ptr_r == PTR_LIMIT) begin
            sel_word = limit_r;
        end else if (ptr_r == PTR_DIE_IDENTIFIER) begin
            sel_word = DIE_IDENTIFIER_VALUE;
        end else begin
            sel_word = ZERO_RESET;
        end
    end

    // arithmetic: products sized for full 16x16 range
    always_comb begin
        mode = cfg_r[CFG_MODE_LSB +: 3];
        avg_n = 11'(1 << AVG_LOG2[cfg_r[CFG_AVG_LSB +: 3]]);
        cur_prod = 32'($signed(shunt_r) * $signed({1'b0, cal_r}));
        pow_prod = 32'(current_r) * 32'(bus_r);
        wr_word = {hold_r, req.data};
        wr_full = req.wr && (phase_r == 2'd2);
        // only the configuration pointer may halt the sequencer; writes to
        // calibration or limits must not stretch a conversion in progress
        cfg_write = wr_full && (ptr_r == PTR_CONFIG);
        // the reset bit acts at the edge of the low byte, so bit 15 never
        // becomes visible in the configuration word
        soft_rst = cfg_write && hold_r[CFG_RST_BIT - 8];
    end

    // byte protocol, register writes and sequencer next state
    always_comb begin
        ptr_nxt = ptr_r;
        phase_nxt = phase_r;
        hold_nxt = hold_r;
        rlow_nxt = rlow_r;
        rd_nxt = rd_r;
        cfg_nxt = cfg_r;
        shunt_nxt = shunt_r;
        bus_nxt = bus_r;
        power_nxt = power_r;
        current_nxt = current_r;
        cal_nxt = cal_r;
        mask_nxt = mask_r;
        limit_nxt = limit_r;
        cfg_wr_nxt = cfg_wr_r;
        ready_nxt = ready_r;
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        smp_nxt = smp_r;
        acc_sh_nxt = acc_sh_r;
        acc_bus_nxt = acc_bus_r;
        busy_nxt = busy_r;
        publish = 1'b0;
        // first write byte of a transaction is the pointer
        if (req.start) begin
            phase_nxt = 2'd0;
        end else if (req.wr) begin
            if (phase_r == 2'd0) begin
                ptr_nxt = req.data;
                phase_nxt = 2'd1;
            end else if (phase_r == 2'd1) begin
                hold_nxt = req.data;
                phase_nxt = 2'd2;
            end else begin
                phase_nxt = 2'd1;                            // next word pair
            end
        end
        // reads: high byte first, low byte captured for coherence
        if (req.rd) begin
            if (phase_r == 2'd2) begin
                rd_nxt = rlow_r;
                phase_nxt = 2'd1;
            end else begin
                rd_nxt = sel_word[15:8];
                rlow_nxt = sel_word[7:0];
                phase_nxt = 2'd2;
            end
        end
        // full word writes; read-only pointers ignore data
        if (wr_full) begin
            if (ptr_r == PTR_CONFIG) begin
                cfg_nxt = (wr_word & CFG_RW_MASK) | CFG_FIXED_VAL;
                cfg_wr_nxt = 1'b1;
                st_nxt = PMRB_IDLE;
                busy_nxt = 1'b0;
            end else if (ptr_r == PTR_CALIB) begin
                cal_nxt = wr_word;
            end else if (ptr_r == PTR_MASK) begin
                mask_nxt = (wr_word & MASK_RW_MASK) | (mask_r & ~MASK_RW_MASK);
            end else if (ptr_r == PTR_LIMIT) begin
                limit_nxt = wr_word;
            end
        end
        // conversion sequencer, stalled while a config write is open
        // a config write has already parked the sequencer at idle, so the
        // conversion after the stop starts from scratch with the new settings
        if (!(cfg_wr_r || cfg_write)) begin
            case (st_r)
                PMRB_IDLE: begin
                    if (mode[1:0] != 2'b00) begin
                        st_nxt = mode[0] ? PMRB_SHUNT : PMRB_BUS;
                        tmr_nxt = mode[0] ? CNT_W'(CT_CYCLES[cfg_r[CFG_SHUNT_CT_LSB +: 3]])
                                          : CNT_W'(CT_CYCLES[cfg_r[CFG_BUS_CT_LSB +: 3]]);
                        smp_nxt = 11'h000;
                        acc_sh_nxt = 27'sh0;
                        acc_bus_nxt = 27'h0;
                        busy_nxt = 1'b1;
                    end
                end
                PMRB_SHUNT: begin
                    if (tmr_r > CNT_W'(1)) begin
                        tmr_nxt = tmr_r - CNT_W'(1);
                    end else begin
                        acc_sh_nxt = acc_sh_r + 27'(sample.shunt);
                        st_nxt = mode[1] ? PMRB_BUS : PMRB_CALC;
                        tmr_nxt = mode[1] ? CNT_W'(CT_CYCLES[cfg_r[CFG_BUS_CT_LSB +: 3]])
                                          : tmr_r;
                        if (!mode[1]) begin
                            smp_nxt = smp_r + 11'h001;
                        end
                    end
                end
                PMRB_BUS: begin
                    if (tmr_r > CNT_W'(1)) begin
                        tmr_nxt = tmr_r - CNT_W'(1);
                    end else begin
                        acc_bus_nxt = acc_bus_r + 27'({1'b0, sample.bus[14:0]});
                        smp_nxt = smp_r + 11'h001;
                        st_nxt = PMRB_CALC;
                    end
                end
                default: begin
                    // more samples needed before publishing an average
                    if (smp_r < avg_n) begin
                        st_nxt = mode[0] ? PMRB_SHUNT : PMRB_BUS;
                        tmr_nxt = mode[0] ? CNT_W'(CT_CYCLES[cfg_r[CFG_SHUNT_CT_LSB +: 3]])
                                          : CNT_W'(CT_CYCLES[cfg_r[CFG_BUS_CT_LSB +: 3]]);
                    end else begin
                        if (mode[0]) begin
                            shunt_nxt = 16'(acc_sh_r >>> AVG_LOG2[cfg_r[CFG_AVG_LSB +: 3]]);
                        end
                        if (mode[1]) begin
                            bus_nxt = 16'(acc_bus_r >> AVG_LOG2[cfg_r[CFG_AVG_LSB +: 3]]);
                        end
                        ready_nxt = 1'b1;
                        publish = 1'b1;
                        busy_nxt = 1'b0;
                        // triggered mode falls back to power-down afterwards
                        if (!mode[2]) begin
                            cfg_nxt = {cfg_r[15:3], 3'b000};
                        end
                        st_nxt = PMRB_IDLE;
                    end
                end
            endcase
        end
        // current and power follow results; zero with no calibration
        if (cal_r == ZERO_RESET) begin
            current_nxt = ZERO_RESET;
            power_nxt = ZERO_RESET;
        end else begin
            current_nxt = cur_prod[CURRENT_SHIFT +: 16];
            power_nxt = 16'(pow_prod / POWER_DIVISOR);
        end
        // new conversion starts once the write sequence has closed
        if (xfer_end) begin
            cfg_wr_nxt = 1'b0;
        end
        // ready flag clears on reading the mask register; a result landing in
        // the same cycle wins, so no completion is ever lost to a read
        if (req.rd && phase_r != 2'd2 && ptr_r == PTR_MASK && !publish) begin
            ready_nxt = 1'b0;
        end
        mask_nxt[MASK_READY_BIT] = ready_nxt;
    end

    // registers; reset and the self-clearing reset bit share defaults
    always_ff @(posedge sys_clk) begin
        // a soft reset restores every default, like power-up; it still counts
        // as a config write, so conversion waits for the stop as usual
        if (rst || soft_rst) begin
            ptr_r <= PTR_CONFIG;
            phase_r <= 2'd0;
            hold_r <= 8'h00;
            rlow_r <= 8'h00;
            rd_r <= 8'h00;
            cfg_r <= CFG_RESET;
            shunt_r <= ZERO_RESET;
            bus_r <= ZERO_RESET;
            power_r <= ZERO_RESET;
            current_r <= ZERO_RESET;
            cal_r <= ZERO_RESET;
            mask_r <= ZERO_RESET;
            limit_r <= ZERO_RESET;
            cfg_wr_r <= !rst;
            ready_r <= 1'b0;
            st_r <= PMRB_IDLE;
            tmr_r <= '0;
            smp_r <= 11'h000;
            acc_sh_r <= 27'sh0;
            acc_bus_r <= 27'h0;
            busy_r <= 1'b0;
        end else begin
            ptr_r <= ptr_nxt;
            phase_r <= phase_nxt;
            hold_r <= hold_nxt;
            rlow_r <= rlow_nxt;
            rd_r <= rd_nxt;
            cfg_r <= cfg_nxt;
            shunt_r <= shunt_nxt;
            bus_r <= bus_nxt;
            power_r <= power_nxt;
            current_r <= current_nxt;
            cal_r <= cal_nxt;
            mask_r <= mask_nxt;
            limit_r <= limit_nxt;
            cfg_wr_r <= cfg_wr_nxt;
            ready_r <= ready_nxt;
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            smp_r <= smp_nxt;
            acc_sh_r <= acc_sh_nxt;
            acc_bus_r <= acc_bus_nxt;
            busy_r <= busy_nxt;
        end
    end

    // outputs straight from flip-flops
    // no logic sits between a register and a port, so the serial front end
    // sees settled values from the edge after each strobe
    always_comb begin
        rd_data = rd_r;
        config_out = cfg_r;
        conv_busy = busy_r;
        conv_ready = ready_r;
    end
endmodule // pmrb_bank

/* rtl/pmrb_pkg.sv */
/*
 * package for the power monitor register bank: pointer map, field layout,
 * reset values, timing counts and the carrier structs.
 * assumes a 20 MHz system clock and a byte-wide serial front end outside.
 */
// Functional notes
// - defaults convert shunt and bus continuously
// - current and power zero while calibration zero
// - all registers volatile, defaults at power-up
// - registers move as two bytes, high first
// - config reads have no side effect
// - config write halts conversion, then restarts
// - bit 15 write resets everything, self-clears
// - bits 14:12 fixed at 100, writes ignored
// - bits 11:9 select 1 to 1024 averages
// - pointers 1,2 hold averaged voltages, read-only
// - pointers 3,4 hold power and current, read-only
// - pointer 5 holds read/write calibration
// - pointer 6 holds alert select, ready flag
// - pointer 7 holds read/write alert limit
// - pointer FF returns text die identifier
// - conversion time codes map 140us to 8.244ms
// - mode bits select power-down, triggered, continuous
// - current equals shunt times calibration over 2048
// - power equals current times bus over 20000
package pmrb_pkg;
    // pointer values
    localparam logic [7:0] PTR_CONFIG = 8'h00;
    localparam logic [7:0] PTR_SHUNT = 8'h01;
    localparam logic [7:0] PTR_BUS = 8'h02;
    localparam logic [7:0] PTR_POWER = 8'h03;
    localparam logic [7:0] PTR_CURRENT = 8'h04;
    localparam logic [7:0] PTR_CALIB = 8'h05;
    localparam logic [7:0] PTR_MASK = 8'h06;
    localparam logic [7:0] PTR_LIMIT = 8'h07;
    localparam logic [7:0] PTR_DIE_IDENTIFIER = 8'hFF;
    // configuration field positions
    localparam int CFG_RST_BIT = 15;
    localparam int CFG_AVG_LSB = 9;
    localparam int CFG_BUS_CT_LSB = 6;
    localparam int CFG_SHUNT_CT_LSB = 3;
    localparam int CFG_MODE_LSB = 0;
    localparam logic [15:0] CFG_FIXED_MASK = 16'h7000;
    localparam logic [15:0] CFG_FIXED_VAL = 16'h4000;
    localparam logic [15:0] CFG_RW_MASK = 16'h0FFF;
    // mask/enable: conversion ready flag position
    localparam int MASK_READY_BIT = 3;
    localparam logic [15:0] MASK_RW_MASK = 16'hFFF0;
    // reset values
    localparam logic [15:0] CFG_RESET = 16'h4127;
    localparam logic [15:0] ZERO_RESET = 16'h0000;
    // die identifier: arbitrary text pair "PM"
    localparam logic [15:0] DIE_IDENTIFIER_VALUE = 16'h504D;
    // arithmetic scale factors
    localparam int CURRENT_SHIFT = 11;
    localparam logic [31:0] POWER_DIVISOR = 32'h0000_4E20;
    // clock and conversion times in nanoseconds
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CT_NS [8] = '{140_000, 204_000, 332_000, 588_000,
                                 1_100_000, 2_116_000, 4_156_000, 8_244_000};
    localparam int CT_CYCLES [8] = '{CT_NS[0] / CLK_PERIOD_NS, CT_NS[1] / CLK_PERIOD_NS,
                                     CT_NS[2] / CLK_PERIOD_NS, CT_NS[3] / CLK_PERIOD_NS,
                                     CT_NS[4] / CLK_PERIOD_NS, CT_NS[5] / CLK_PERIOD_NS,
                                     CT_NS[6] / CLK_PERIOD_NS, CT_NS[7] / CLK_PERIOD_NS};
    localparam int CNT_W = 18;
    // averaging exponent per code: 1,4,16,64,128,256,512,1024
    localparam int AVG_LOG2 [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

    // conversion sequencer states
    typedef enum logic [1:0] {PMRB_IDLE, PMRB_SHUNT, PMRB_BUS, PMRB_CALC} pmrb_state_t;

    // byte bus from the serial front end
    typedef struct packed {
        logic start;      // new transaction, next write byte is the pointer
        logic wr;         // write byte strobe
        logic rd;         // read byte strobe
        logic [7:0] data; // write data
    } pmrb_req_t;

    // raw samples from the converter
    typedef struct packed {
        logic signed [15:0] shunt;
        logic [15:0] bus;
    } pmrb_sample_t;
endpackage : pmrb_pkg
